/* File: verification/octal_switch_serial_control_test.sv */
// self-checking bench for the octal switch serial control block
`timescale 1ns/1ps
`default_nettype none
module octal_switch_serial_control_test;
	logic ref_clk, rst_b, enable, overvoltage, cs_b, sclk, din, dout, oe;
	logic miso_last = 1'b0;
	wire logic miso;
	logic [7:0] oc, tl, ol, out_on, det_on;
	logic [15:0] cmd;
	logic [31:0] rx;
	int n_fail, total_checks;
	octal_switch_serial_control dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.enable(enable), .chip_select_b(cs_b), .serial_clock(sclk),
		.serial_command_in(din), .serial_status_out(dout),
		.serial_status_oe(oe), .overcurrent(oc), .thermal_limit(tl),
		.open_load(ol), .overvoltage(overvoltage), .output_on(out_on),
		.detect_current_on(det_on), .channel_command_word(cmd));
	spi_host_model host (.ref_clk(ref_clk), .cs_b(cs_b), .sclk(sclk),
		.mosi(din), .miso(miso));
	// released line shows the inverse of its last driven bit
	always @(posedge ref_clk) if (oe) miso_last <= dout;
	assign miso = oe ? dout : ~miso_last;
	// ----------------
	// compare and verdict
	// ----------------
	task automatic check_w(input sw_pkg::word_t got, input sw_pkg::word_t exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: word %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_c(input sw_pkg::chan_t got, input sw_pkg::chan_t exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: byte %h want %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end
	// ----------------
	// main sequence
	// ----------------
	initial begin
		rst_b = 1'b0;
		enable = 1'b1;
		overvoltage = 1'b0;
		oc = 8'h00;
		tl = 8'h00;
		ol = 8'h00;
		n_fail = 0;
		total_checks = 0;
		host.tick(8);
		rst_b = 1'b1;
		host.tick(4);
		check_w(cmd, 16'h0000);
		check_c({7'h00, oe}, 8'h00);
		host.xfer(32'h0000a5c3, 16, rx);
		check_w(rx[15:0], 16'h0000);
		check_w(cmd, 16'ha5c3);
		check_c(out_on, 8'hc3);
		check_c(det_on, 8'ha5);
		// ch1 short while on, ch8 hot, ch3 open with current, ch4 without
		oc = 8'h01;
		tl = 8'h80;
		ol = 8'h0c;
		host.tick(20);
		check_c(out_on, 8'h43);
		host.xfer(32'h0000a5c3, 16, rx);
		check_w(rx[15:0], 16'h0085);
		oc = 8'h00;
		tl = 8'h00;
		ol = 8'h00;
		host.tick(20);
		check_c(out_on, 8'hc3);
		overvoltage = 1'b1;
		host.tick(10);
		check_c(out_on, 8'h00);
		overvoltage = 1'b0;
		host.tick(10);
		check_c(out_on, 8'hc3);
		host.xfer(32'h12340f0f, 32, rx);
		check_w(rx[31:16], 16'h0000);
		check_w(rx[15:0], 16'h1234);
		check_w(cmd, 16'h0f0f);
		host.xfer(32'h0001ffff, 17, rx);
		check_w(cmd, 16'h0f0f);
		host.xfer(32'h00ab3c5a, 24, rx);
		check_w(cmd, 16'h3c5a);
		check_c({7'h00, oe}, 8'h00);
		// ch2,4,5,7 shorted while on, ch1-7 hot, ch6 open with current
		oc = 8'hfe;
		tl = 8'h7f;
		ol = 8'hf3;
		host.tick(20);
		check_c(out_on, 8'h00);
		host.xfer(32'h000000f0, 16, rx);
		check_w(rx[15:0], 16'h007f);
		check_w(cmd, 16'h00f0);
		// ch1-4 off with no detection current: open loads stay silent
		oc = 8'h00;
		tl = 8'h00;
		ol = 8'hff;
		host.tick(20);
		check_c(out_on, 8'hf0);
		check_c(det_on, 8'h00);
		host.xfer(32'h000000f0, 16, rx);
		check_w(rx[15:0], 16'h0000);
		enable = 1'b0;
		host.tick(10);
		check_w(cmd, 16'h0000);
		check_c(out_on, 8'h00);
		check_c(det_on, 8'h00);
		// wake, then a reset in mid-run must clear the applied word
		enable = 1'b1;
		host.tick(4);
		host.xfer(32'h0000ff00, 16, rx);
		check_w(rx[15:0], 16'h0000);
		check_c(det_on, 8'hff);
		rst_b = 1'b0;
		host.tick(4);
		rst_b = 1'b1;
		host.tick(4);
		check_w(cmd, 16'h0000);
		check_c(det_on, 8'h00);
		host.xfer(32'h00000081, 16, rx);
		check_w(rx[15:0], 16'h0000);
		check_c(out_on, 8'h81);
		complete_run();
	end
endmodule
`default_nettype wire

/* File: verification/spi_host_model.sv */
// host serial master model driving the switch's select, clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic ref_clk,
	output logic cs_b,
	output logic sclk,
	output logic mosi,
	input wire logic miso
);
	// ----------------
	// frame engine
	// ----------------
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic xfer(input logic [31:0] tx, input int n,
		output logic [31:0] rx);
		rx = '0;
		tick(1);
		cs_b = 1'b0;
		tick(4);
		for (int i = n - 1; i >= 0; i--) begin
			mosi = tx[i];
			sclk = 1'b1;
			tick(12);
			// sampled late in the high phase, long after the shift
			rx = {rx[30:0], miso};
			sclk = 1'b0;
			tick(13);
		end
		cs_b = 1'b1;
		// idle line must not keep showing the last bit
		mosi = ~mosi;
		tick(20);
	endtask
endmodule
`default_nettype wire

/* File: verilog/cmd_buffer.sv */
// two-entry command word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sw_defs.svh"
module cmd_buffer (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [15:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_data
);
	logic [15:0] mem_r [0:1];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rd_ptr_r];
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else if (clr) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end
endmodule
`default_nettype wire

/* File: verilog/octal_switch_serial_control.sv */
// serial control and fault readout of an eight channel power switch
`timescale 1ns/1ps
`default_nettype none
`include "sw_defs.svh"
module octal_switch_serial_control (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic chip_select_b,
	input wire logic serial_clock,
	input wire logic serial_command_in,
	output logic serial_status_out,
	output logic serial_status_oe,
	input wire logic [7:0] overcurrent,
	input wire logic [7:0] thermal_limit,
	input wire logic [7:0] open_load,
	input wire logic overvoltage,
	output logic [7:0] output_on,
	output logic [7:0] detect_current_on,
	output logic [15:0] channel_command_word
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic sclk_d_r;
	logic cs_d_r;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 4'h1;
			sync_r <= 4'h1;
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			meta_r <= {enable, serial_command_in, serial_clock,
				chip_select_b};
			sync_r <= meta_r;
			sclk_d_r <= sync_r[1];
			cs_d_r <= sync_r[0];
		end
	end
	wire cs_s = sync_r[0];
	wire sclk_s = sync_r[1];
	wire din_s = sync_r[2];
	wire en_s = sync_r[3];
	wire cs_fall = cs_d_r && !cs_s;
	wire cs_rise = !cs_d_r && cs_s;
	// select high gates the clock away entirely
	wire sclk_fall = !cs_s && sclk_d_r && !sclk_s;
	wire sclk_rise = !cs_s && !sclk_d_r && sclk_s;

	// ------------------------------------------------------------
	// fault gathering
	// ------------------------------------------------------------
	function automatic logic [7:0] fault_map(input logic [7:0] cmd_on,
		input logic [7:0] det, input logic [7:0] oc,
		input logic [7:0] ot, input logic [7:0] ol);
		fault_map = ot | (oc & cmd_on) | (ol & ~cmd_on & det);
	endfunction
	logic [15:0] cmd_r;
	logic [7:0] fault_r;
	wire [7:0] fault_now = fault_map(cmd_r[7:0], cmd_r[15:8], overcurrent,
		thermal_limit, open_load);

	// ------------------------------------------------------------
	// shift register and pulse counter
	// ------------------------------------------------------------
	sw_pkg::frame_e state_r;
	sw_pkg::frame_e state_nxt;
	logic [15:0] shift_r;
	logic sout_r;
	logic [5:0] pulses_r;
	logic over_r;
	wire [5:0] pulses_inc = pulses_r + 6'h01;
	wire frame_ok = !over_r && (pulses_r >= `SW_MIN_PULSES) &&
		((pulses_r & `SW_GROUP_MASK) == 6'h00);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sw_pkg::ST_IDLE:
				if (cs_fall)
					state_nxt = sw_pkg::ST_FRAME;
			sw_pkg::ST_FRAME:
				if (cs_rise)
					state_nxt = frame_ok ? sw_pkg::ST_COMMIT
						: sw_pkg::ST_IDLE;
			sw_pkg::ST_COMMIT:
				state_nxt = sw_pkg::ST_IDLE;
			default:
				state_nxt = sw_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			state_r <= sw_pkg::ST_IDLE;
		else if (!en_s)
			state_r <= sw_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_r <= `SW_CMD_RESET;
			sout_r <= 1'b0;
			pulses_r <= 6'h00;
			over_r <= 1'b0;
		end else if (cs_fall) begin
			shift_r <= {`SW_STAT_HI_ZERO, fault_r};
			sout_r <= 1'b0;
			pulses_r <= 6'h00;
			over_r <= 1'b0;
		end else if (sclk_rise) begin
			sout_r <= shift_r[15];
		end else if (sclk_fall) begin
			shift_r <= {shift_r[14:0], din_s};
			pulses_r <= pulses_inc;
			if (pulses_r == `SW_MAX_PULSES)
				over_r <= 1'b1;
		end
	end
	assign serial_status_oe = !cs_s;
	assign serial_status_out = sout_r;

	// ------------------------------------------------------------
	// command path through the buffer
	// ------------------------------------------------------------
	wire buf_in_ready;
	wire buf_out_valid;
	wire [15:0] buf_out_data;
	cmd_buffer u_buf (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clr(!en_s),
		.in_valid(state_r == sw_pkg::ST_COMMIT),
		.in_ready(buf_in_ready),
		.in_data(shift_r),
		.out_valid(buf_out_valid),
		.out_ready(1'b1),
		.out_data(buf_out_data)
	);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_r <= `SW_CMD_RESET;
			fault_r <= 8'h00;
		end else if (!en_s) begin
			cmd_r <= `SW_CMD_RESET;
			fault_r <= 8'h00;
		end else begin
			if (buf_out_valid)
				cmd_r <= buf_out_data;
			fault_r <= cs_s ? fault_now : fault_r;
		end
	end
	assign channel_command_word = cmd_r;

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	logic [7:0] on_r;
	logic [7:0] det_r;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			on_r <= 8'h00;
			det_r <= 8'h00;
		end else begin
			on_r <= (en_s && !overvoltage) ?
				(cmd_r[7:0] & ~thermal_limit) : 8'h00;
			det_r <= en_s ? cmd_r[15:8] : 8'h00;
		end
	end
	assign output_on = on_r;
	assign detect_current_on = det_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// commit: buffer must have room, word lands two cycles on and is checked on the third
	sequence s_commit;
		state_r == sw_pkg::ST_COMMIT && en_s;
	endsequence
	sequence s_commit_settle;
		s_commit ##1 en_s [*2];
	endsequence
	property p_commit_applies;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit_settle |=> cmd_r == $past(shift_r, 3);
	endproperty
	a_commit_applies: assert property (p_commit_applies)
		else $error("command not applied after commit");
	property p_buf_room;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit |-> buf_in_ready;
	endproperty
	a_buf_room: assert property (p_buf_room)
		else $error("command buffer full at commit");

	// frame end: only 16 plus whole bytes of pulses commit
	sequence s_frame_end;
		state_r == sw_pkg::ST_FRAME && cs_rise;
	endsequence
	property p_bad_frame;
		@(posedge ref_clk) disable iff (!rst_b)
		s_frame_end ##0 !frame_ok |=> state_r == sw_pkg::ST_IDLE;
	endproperty
	a_bad_frame: assert property (p_bad_frame)
		else $error("bad pulse count frame accepted");
	property p_good_frame;
		@(posedge ref_clk) disable iff (!rst_b)
		s_frame_end ##0 frame_ok && en_s |=>
			state_r == sw_pkg::ST_COMMIT;
	endproperty
	a_good_frame: assert property (p_good_frame)
		else $error("well formed frame dropped");

	// link edges: sample on fall, launch on rise, idle ignored
	property p_shift_in;
		@(posedge ref_clk) disable iff (!rst_b)
		sclk_fall && !cs_fall |=> shift_r[0] == $past(din_s);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("input bit not sampled on falling clock");
	property p_msb_out;
		@(posedge ref_clk) disable iff (!rst_b)
		sclk_rise |=> serial_status_out == $past(shift_r[15]);
	endproperty
	a_msb_out: assert property (p_msb_out)
		else $error("wrong bit shifted out");
	property p_ignore_idle;
		@(posedge ref_clk) disable iff (!rst_b)
		cs_s |=> $stable(shift_r) && $stable(pulses_r) &&
			$stable(serial_status_out);
	endproperty
	a_ignore_idle: assert property (p_ignore_idle)
		else $error("link activity taken while deselected");
	property p_oe;
		@(posedge ref_clk) disable iff (!rst_b)
		serial_status_oe == !$past(chip_select_b, 2);
	endproperty
	a_oe: assert property (p_oe)
		else $error("data out drive does not follow select");
	property p_preload;
		@(posedge ref_clk) disable iff (!rst_b)
		cs_fall |=> shift_r[15:8] == 8'h00 &&
			shift_r[7:0] == $past(fault_r);
	endproperty
	a_preload: assert property (p_preload)
		else $error("status not preloaded");

	// fault word: previous period, per channel sources
	property p_fault_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		!cs_s && en_s |=> $stable(fault_r);
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault word moved during a frame");
	property p_hot_flag;
		@(posedge ref_clk) disable iff (!rst_b)
		en_s && cs_s |=>
			(fault_r & $past(thermal_limit)) == $past(thermal_limit);
	endproperty
	a_hot_flag: assert property (p_hot_flag)
		else $error("overtemperature not flagged");
	wire [7:0] short_seen = overcurrent & cmd_r[7:0];
	property p_short_flag;
		@(posedge ref_clk) disable iff (!rst_b)
		en_s && cs_s |=>
			(fault_r & $past(short_seen)) == $past(short_seen);
	endproperty
	a_short_flag: assert property (p_short_flag)
		else $error("short on driven output not flagged");
	property p_open_load;
		@(posedge ref_clk) disable iff (!rst_b)
		en_s && cs_s && thermal_limit == 8'h00 && overcurrent == 8'h00 &&
			cmd_r[15:8] == 8'h00 |=> fault_r == 8'h00;
	endproperty
	a_open_load: assert property (p_open_load)
		else $error("open load flagged without current");

	// drivers: gating by supply, temperature and enable
	property p_drive;
		@(posedge ref_clk) disable iff (!rst_b)
		en_s && !overvoltage && thermal_limit == 8'h00 |=>
			output_on == $past(cmd_r[7:0]);
	endproperty
	a_drive: assert property (p_drive)
		else $error("outputs do not follow command");
	property p_detect;
		@(posedge ref_clk) disable iff (!rst_b)
		en_s |=> detect_current_on == $past(cmd_r[15:8]);
	endproperty
	a_detect: assert property (p_detect)
		else $error("detection current does not follow command");
	property p_ov_off;
		@(posedge ref_clk) disable iff (!rst_b)
		overvoltage |=> output_on == 8'h00;
	endproperty
	a_ov_off: assert property (p_ov_off)
		else $error("output on during overvoltage");
	property p_ot_off;
		@(posedge ref_clk) disable iff (!rst_b)
		thermal_limit != 8'h00 |=>
			(output_on & $past(thermal_limit)) == 8'h00;
	endproperty
	a_ot_off: assert property (p_ot_off)
		else $error("hot output still on");
	property p_sleep;
		@(posedge ref_clk) disable iff (!rst_b)
		!en_s |=> cmd_r == 16'h0000 ##1 detect_current_on == 8'h00;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep did not clear");
	property p_sleep_off;
		@(posedge ref_clk) disable iff (!rst_b)
		!en_s |=> output_on == 8'h00;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("outputs on while disabled");
endmodule
`default_nettype wire

/* File: verilog/sw_defs.svh */
// constants for the octal switch serial control block
`ifndef SW_DEFS_SVH
`define SW_DEFS_SVH
`define SW_WORD_W 16
`define SW_CH_N 8
`define SW_CMD_OUT_LSB 0
`define SW_CMD_DET_LSB 8
`define SW_CMD_RESET 16'h0000
`define SW_STAT_HI_ZERO 8'h00
`define SW_MIN_PULSES 6'h10
`define SW_GROUP_MASK 6'h07
`define SW_MAX_PULSES 6'h3f
`define SW_BUF_DEPTH 2
`endif

/* File: verilog/sw_pkg.sv */
// types for the octal switch serial control block
`default_nettype none
package sw_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0] chan_t;
	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_COMMIT} frame_e;
endpackage
`default_nettype wire
